// File: cmof_pkg.sv
`default_nettype none
package cmof_pkg;
    // ==========================================
    // Geometry
    localparam int unsigned NUM_OBJ = 16;
    localparam int unsigned OBJ_W   = 4;
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned ADDR_W  = 8;
    // ==========================================
    // Register offsets
    localparam logic [7:0] RX_READY_LOW        = 8'h04;
    localparam logic [7:0] RX_READY_HIGH       = 8'h05;
    localparam logic [7:0] RX_IRQ_MASK_LOW     = 8'h06;
    localparam logic [7:0] RX_IRQ_MASK_HIGH    = 8'h07;
    localparam logic [7:0] TX_REQUEST_SET_LOW  = 8'h08;
    localparam logic [7:0] TX_REQUEST_SET_HIGH = 8'h09;
    localparam logic [7:0] TX_CANCEL_LOW       = 8'h18;
    localparam logic [7:0] TX_CANCEL_HIGH      = 8'h19;
    localparam logic [7:0] REMOTE_PENDING_LOW  = 8'h1A;
    localparam logic [7:0] REMOTE_PENDING_HIGH = 8'h1B;
    // ==========================================
    // Reset and fixed read values
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [7:0]  READ_NONE   = 8'h00;
    // ==========================================
    // Transmit scheduler states
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_BUSY = 1'b1
    } cmof_txstate_type;
endpackage
`default_nettype wire

// File: cmof_flags.sv
// Contract
// - Received message sets object's ready flag
// - Host writes zero to clear ready
// - Ready set with mask raises interrupt
// - Mask zero gives no interrupt
// - Global enable off suppresses all interrupts
// - Global enable one allows interrupts
// - Pending request starts object transmission
// - Completed transmission clears its request
// - Pending requests served highest object first
// - Host write one sets request
// - Cancel clears request unless transmitting
// - Cancel registers are write only
// - Unanswered remote frame sets pending flag
// - Sixteen bits, low byte objects 0-7
// - Reset clears all flag vectors
`default_nettype none
module cmof_flags #(
    parameter int unsigned NUM_OBJ = cmof_pkg::NUM_OBJ
) (
    input  wire logic        mclk,              // System clock
    input  wire logic        rst_n,             // Async reset
    input  wire logic [7:0]  regAddr,           // Host register address
    input  wire logic [7:0]  regWrData,         // Host write data
    input  wire logic        regWr,             // Host write strobe
    input  wire logic        regRd,             // Host read strobe
    output logic      [7:0]  regRdData,         // Host read data
    input  wire logic        rxIrqGlobalEnable, // Global receive irq enable
    input  wire logic        rxStore,           // Message stored pulse
    input  wire logic [3:0]  rxObj,             // Object of stored message
    input  wire logic        remoteRx,          // Remote frame received pulse
    input  wire logic [3:0]  remoteObj,         // Object of remote frame
    input  wire logic        txDone,            // Transmission completed pulse
    output logic             txStart,           // Start transmit pulse
    output logic      [3:0]  txObj,             // Object being sent
    output logic             txBusy,            // Transmission in progress
    output logic             rxIrq,             // Receive interrupt pulse
    output logic [NUM_OBJ-1:0] txPending        // Request vector view
);
    // ==========================================
    // Host access decode
    logic wrRdyLo;
    logic wrRdyHi;
    logic wrMskLo;
    logic wrMskHi;
    logic wrSetLo;
    logic wrSetHi;
    logic wrCanLo;
    logic wrCanHi;
    logic [15:0] wrWide;

    always_comb begin
        wrRdyLo = regWr && (regAddr == cmof_pkg::RX_READY_LOW);
        wrRdyHi = regWr && (regAddr == cmof_pkg::RX_READY_HIGH);
        wrMskLo = regWr && (regAddr == cmof_pkg::RX_IRQ_MASK_LOW);
        wrMskHi = regWr && (regAddr == cmof_pkg::RX_IRQ_MASK_HIGH);
        wrSetLo = regWr && (regAddr == cmof_pkg::TX_REQUEST_SET_LOW);
        wrSetHi = regWr && (regAddr == cmof_pkg::TX_REQUEST_SET_HIGH);
        wrCanLo = regWr && (regAddr == cmof_pkg::TX_CANCEL_LOW);
        wrCanHi = regWr && (regAddr == cmof_pkg::TX_CANCEL_HIGH);
        wrWide  = {regWrData, regWrData};
    end

    // ==========================================
    // Receive ready flags and masks
    logic [15:0] rxReady_ff;
    logic [15:0] nxt_rxReady;
    logic [15:0] rxMask_ff;
    logic [15:0] nxt_rxMask;
    logic [15:0] rdyKeep;
    logic [15:0] rxSetVec;
    logic        rxIrq_ff;
    logic        nxt_rxIrq;

    always_comb begin
        // Low byte holds objects 0-7, high byte 8-15
        rdyKeep = 16'hFFFF;
        if (wrRdyLo) begin
            rdyKeep[7:0] = regWrData;
        end
        if (wrRdyHi) begin
            rdyKeep[15:8] = regWrData;
        end
        rxSetVec = '0;
        if (rxStore) begin
            rxSetVec[rxObj] = 1'b1;
        end
        // Set wins so a message landing during a clear is kept
        nxt_rxReady = (rxReady_ff & rdyKeep) | rxSetVec;
        nxt_rxMask = rxMask_ff;
        if (wrMskLo) begin
            nxt_rxMask[7:0] = regWrData;
        end
        if (wrMskHi) begin
            nxt_rxMask[15:8] = regWrData;
        end
        nxt_rxIrq = rxStore && rxMask_ff[rxObj]
                    && rxIrqGlobalEnable;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rxReady_ff <= cmof_pkg::FLAGS_RESET;
            rxMask_ff  <= cmof_pkg::FLAGS_RESET;
            rxIrq_ff   <= 1'b0;
        end else begin
            rxReady_ff <= nxt_rxReady;
            rxMask_ff  <= nxt_rxMask;
            rxIrq_ff   <= nxt_rxIrq;
        end
    end

    // ==========================================
    // Transmit requests and scheduler
    cmof_pkg::cmof_txstate_type txState_ff;
    cmof_pkg::cmof_txstate_type nxt_txState;
    logic [15:0] txReq_ff;
    logic [15:0] nxt_txReq;
    logic [3:0]  txObj_ff;
    logic [3:0]  nxt_txObj;
    logic        txStart_ff;
    logic        nxt_txStart;
    logic [15:0] txSetVec;
    logic [15:0] txCanVec;
    logic [15:0] txDoneVec;
    logic [3:0]  pick;

    always_comb begin
        pick = '0;
        // Ascending scan, so the highest pending object wins
        for (int i = 0; i < 16; i++) begin
            if (txReq_ff[i]) begin
                pick = 4'(i);
            end
        end
    end

    always_comb begin
        txSetVec = '0;
        txCanVec = '0;
        txDoneVec = '0;
        if (wrSetLo) begin
            txSetVec[7:0] = regWrData;
        end
        if (wrSetHi) begin
            txSetVec[15:8] = regWrData;
        end
        if (wrCanLo) begin
            txCanVec[7:0] = wrWide[7:0];
        end
        if (wrCanHi) begin
            txCanVec[15:8] = wrWide[15:8];
        end
        if (txState_ff == cmof_pkg::TX_BUSY) begin
            txCanVec[txObj_ff] = 1'b0;
            if (txDone) begin
                txDoneVec[txObj_ff] = 1'b1;
            end
        end
        // Set wins: a host set overrides a cancel or a completion on the same bit
        nxt_txReq = (txReq_ff & ~txCanVec & ~txDoneVec)
                    | txSetVec;
        nxt_txState = txState_ff;
        nxt_txObj   = txObj_ff;
        nxt_txStart = 1'b0;
        unique case (txState_ff)
            cmof_pkg::TX_IDLE: begin
                if (|txReq_ff) begin
                    nxt_txState = cmof_pkg::TX_BUSY;
                    nxt_txObj   = pick;
                    nxt_txStart = 1'b1;
                end
            end
            cmof_pkg::TX_BUSY: begin
                if (txDone) begin
                    nxt_txState = cmof_pkg::TX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            txState_ff <= cmof_pkg::TX_IDLE;
            txReq_ff   <= cmof_pkg::FLAGS_RESET;
            txObj_ff   <= '0;
            txStart_ff <= 1'b0;
        end else begin
            txState_ff <= nxt_txState;
            txReq_ff   <= nxt_txReq;
            txObj_ff   <= nxt_txObj;
            txStart_ff <= nxt_txStart;
        end
    end

    // ==========================================
    // Remote request pending flags
    logic [15:0] rmtPend_ff;
    logic [15:0] nxt_rmtPend;

    always_comb begin
        // An answer completing frees the flag; a new remote frame wins
        nxt_rmtPend = rmtPend_ff & ~txDoneVec;
        if (remoteRx) begin
            nxt_rmtPend[remoteObj] = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rmtPend_ff <= cmof_pkg::FLAGS_RESET;
        end else begin
            rmtPend_ff <= nxt_rmtPend;
        end
    end

    // ==========================================
    // Read path
    logic [7:0] rdData_ff;
    logic [7:0] nxt_rdData;

    always_comb begin
        nxt_rdData = rdData_ff;
        if (regRd) begin
            unique case (regAddr)
                cmof_pkg::RX_READY_LOW:        nxt_rdData = rxReady_ff[7:0];
                cmof_pkg::RX_READY_HIGH:       nxt_rdData = rxReady_ff[15:8];
                cmof_pkg::RX_IRQ_MASK_LOW:     nxt_rdData = rxMask_ff[7:0];
                cmof_pkg::RX_IRQ_MASK_HIGH:    nxt_rdData = rxMask_ff[15:8];
                cmof_pkg::TX_REQUEST_SET_LOW:  nxt_rdData = txReq_ff[7:0];
                cmof_pkg::TX_REQUEST_SET_HIGH: nxt_rdData = txReq_ff[15:8];
                cmof_pkg::REMOTE_PENDING_LOW:  nxt_rdData = rmtPend_ff[7:0];
                cmof_pkg::REMOTE_PENDING_HIGH: nxt_rdData = rmtPend_ff[15:8];
                // Cancel registers and unmapped offsets read as zero
                default:                       nxt_rdData = cmof_pkg::READ_NONE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_ff <= cmof_pkg::READ_NONE;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    assign regRdData = rdData_ff;
    assign txStart   = txStart_ff;
    assign txObj     = txObj_ff;
    assign txBusy    = txState_ff;
    assign rxIrq     = rxIrq_ff;
    assign txPending = txReq_ff;

    // ==========================================
    // Checks
    sequence storeMasked;
        rxStore && rxMask_ff[rxObj] && rxIrqGlobalEnable;
    endsequence

    sequence idleWithWork;
        txState_ff == cmof_pkg::TX_IDLE && |txReq_ff;
    endsequence

    sequence busyCancel;
        txState_ff == cmof_pkg::TX_BUSY && (wrCanLo || wrCanHi) && !txDone;
    endsequence

    chk_rx_set_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        rxStore |=> rxReady_ff[$past(rxObj)])
        else $error("ready flag not set after store");

    chk_rx_host_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (wrRdyLo && !rxStore) |=> (rxReady_ff[7:0] & ~$past(regWrData)) == 8'h00)
        else $error("ready flag not cleared by zero write");

    chk_irq_fires: assert property (@(posedge mclk) disable iff (!rst_n)
        storeMasked |=> rxIrq_ff)
        else $error("receive interrupt missing");

    chk_irq_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        rxIrq_ff |-> $past(rxIrqGlobalEnable) && $past(rxStore))
        else $error("interrupt while disabled or without store");

    chk_tx_highest: assert property (@(posedge mclk) disable iff (!rst_n)
        idleWithWork |=> txStart_ff && txObj_ff == $past(pick) ##1 !txStart_ff)
        else $error("wrong object or start width");

    chk_tx_done_clr: assert property (@(posedge mclk) disable iff (!rst_n)
        (txBusy && txDone && !wrSetLo && !wrSetHi) |=> !txReq_ff[$past(txObj_ff)])
        else $error("request not cleared after transmission");

    chk_cancel_guard: assert property (@(posedge mclk) disable iff (!rst_n)
        busyCancel |=> txReq_ff[txObj_ff] == $past(txReq_ff[txObj_ff]))
        else $error("active request cancelled");

    chk_remote_set: assert property (@(posedge mclk) disable iff (!rst_n)
        remoteRx |=> rmtPend_ff[$past(remoteObj)])
        else $error("remote pending not set");

    chk_irq_masked: assert property (@(posedge mclk) disable iff (!rst_n)
        (rxStore && !rxMask_ff[rxObj]) |=> !rxIrq_ff)
        else $error("interrupt from masked object");

    chk_tx_host_set: assert property (@(posedge mclk) disable iff (!rst_n)
        wrSetLo |=> (txReq_ff[7:0] & $past(regWrData)) == $past(regWrData))
        else $error("request set lost");

    chk_remote_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (txBusy && txDone && !remoteRx) |=> !rmtPend_ff[$past(txObj_ff)])
        else $error("remote pending not cleared by answer");
endmodule
`default_nettype wire

// File: cmof_engine_model.sv
`default_nettype none
module cmof_engine_model (
    input  wire logic       mclk,    // System clock
    input  wire logic       rst_n,   // Async reset
    input  wire logic       txStart, // Frame start pulse
    input  wire logic [7:0] latency, // Frame length in cycles
    output logic            txDone   // Frame sent pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Frame timer; latency 0 is not supported, it never raises txDone
    logic [7:0] remain_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            remain_ff <= 8'h00;
            txDone    <= 1'b0;
        end else begin
            txDone <= (remain_ff == 8'h01);
            if (txStart) begin
                remain_ff <= latency;
            end else if (remain_ff != 8'h00) begin
                remain_ff <= remain_ff - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: can_message_object_flags_bench.sv
`default_nettype none
module can_message_object_flags_bench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [7:0]  regWrData = 8'h00;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [7:0]  regRdData;
    logic        rxIrqEn = 1'b0;
    logic        rxStore = 1'b0;
    logic [3:0]  rxObj = 4'h0;
    logic        remoteRx = 1'b0;
    logic [3:0]  remoteObj = 4'h0;
    logic        txDone;
    logic        txStart;
    logic        txBusy;
    logic        rxIrq;
    logic [3:0]  txObj;
    logic [15:0] txPending;
    logic [7:0]  engLat = 8'h14;
    logic        irqSeen;
    int          n_fail = 0;
    int          n_tests = 0;
    cmof_flags uut (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rxIrqGlobalEnable(rxIrqEn),
        .rxStore(rxStore), .rxObj(rxObj), .remoteRx(remoteRx), .remoteObj(remoteObj),
        .txDone(txDone), .txStart(txStart), .txObj(txObj), .txBusy(txBusy), .rxIrq(rxIrq),
        .txPending(txPending));
    cmof_engine_model engine (.mclk(mclk), .rst_n(rst_n), .txStart(txStart),
        .latency(engLat), .txDone(txDone));
    initial begin
        forever #4 mclk = ~mclk;
    end
    // ==========================================
    // Host bus and engine helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge mclk);
        regWr     <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd   <= 1'b0;
        #1;
        `CHK(regRdData, e)
    endtask
    task automatic store(input logic [3:0] o);
        @(posedge mclk);
        rxStore <= 1'b1;
        rxObj   <= o;
        @(posedge mclk);
        rxStore <= 1'b0;
        #1;
        irqSeen = rxIrq;
    endtask
    // Pulse is one cycle wide, so poll every cycle under a bound
    task automatic wait_start(input logic [3:0] o);
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            #1;
            k++;
        end while (txStart !== 1'b1 && k < 200);
        `CHK(txStart, 1'b1)
        `CHK(txObj, o)
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] adr [11] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                                 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h0C};
        foreach (adr[i]) rdchk(adr[i], 8'h00);
        `CHK(txPending, 16'h0000)
        $display("test reset done");
    endtask
    task automatic t_rx();
        @(posedge mclk);
        rxIrqEn <= 1'b1;
        wr(8'h07, 8'h02);
        store(4'd9);
        `CHK(irqSeen, 1'b1)
        store(4'd3);
        `CHK(irqSeen, 1'b0)
        rdchk(8'h05, 8'h02);
        rdchk(8'h04, 8'h08);
        rdchk(8'h07, 8'h02);
        wr(8'h05, 8'hFF);
        rdchk(8'h05, 8'h02);
        wr(8'h05, 8'hFD);
        rdchk(8'h05, 8'h00);
        @(posedge mclk);
        rxIrqEn <= 1'b0;
        store(4'd9);
        `CHK(irqSeen, 1'b0)
        @(posedge mclk);
        rxIrqEn <= 1'b1;
        store(4'd9);
        `CHK(irqSeen, 1'b1)
        wr(8'h06, 8'h08);
        store(4'd3);
        `CHK(irqSeen, 1'b1)
        rdchk(8'h06, 8'h08);
        wr(8'h04, 8'hF7);
        rdchk(8'h04, 8'h00);
        // Flags must survive idle time with no host clear
        repeat (20) @(posedge mclk);
        rdchk(8'h05, 8'h02);
        $display("test receive done");
    endtask
    task automatic t_tx();
        wr(8'h08, 8'h02);
        wait_start(4'd1);
        wr(8'h08, 8'h21);
        wr(8'h09, 8'h80);
        wr(8'h09, 8'h02);
        wr(8'h19, 8'h02);
        wr(8'h18, 8'h02);
        wr(8'h18, 8'h01);
        #1;
        `CHK(txPending, 16'h8022)
        `CHK(txBusy, 1'b1)
        // Read while requests are live, so a leak of them would show
        rdchk(8'h18, 8'h00);
        wait_start(4'd15);
        wait_start(4'd5);
        repeat (30) @(posedge mclk);
        #1;
        `CHK(txPending, 16'h0000)
        `CHK(txBusy, 1'b0)
        $display("test transmit done");
    endtask
    task automatic t_remote();
        @(posedge mclk);
        engLat    <= 8'h02;
        remoteRx  <= 1'b1;
        remoteObj <= 4'd12;
        @(posedge mclk);
        remoteRx  <= 1'b0;
        rdchk(8'h1B, 8'h10);
        wr(8'h1B, 8'h00);
        rdchk(8'h1B, 8'h10);
        wr(8'h09, 8'h10);
        wait_start(4'd12);
        repeat (10) @(posedge mclk);
        rdchk(8'h1B, 8'h00);
        $display("test remote done");
    endtask
    // Reset in mid-run with ready flags, masks and a request all live
    task automatic t_reset_mid();
        wr(8'h09, 8'h40);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        `CHK(txBusy, 1'b0)
        `CHK(txStart, 1'b0)
        t_reset();
    endtask
    // ==========================================
    // Verdict
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_rx();
        t_tx();
        t_remote();
        t_reset_mid();
        tally_and_finish();
    end
    // Whole run is well under 1000 cycles
    initial begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
